// *** core/pmtr_table_read.sv ***
`timescale 1ns/1ps
// table read sequencer: decodes the opcode, steps the byte pointer,
// reads program memory and fills the table latch
module pmtr_table_read #(
  parameter int ADDR_W = pmtr_pkg::ADDR_W,
  parameter int DATA_W = pmtr_pkg::DATA_W,
  parameter int WORD_W = pmtr_pkg::WORD_W
) (
  input  wire logic                          core_clk,
  input  wire logic                          rst,
  input  wire logic [pmtr_pkg::OPC_W-1:0]    instrWord,
  input  wire logic                          instrValid,
  input  wire logic                          ptrLoad,
  input  wire logic [ADDR_W-1:0]             ptrLoadData,
  input  wire logic [WORD_W-1:0]             memRdData,
  output logic      [ADDR_W-1:0]             tablePointer,
  output logic      [DATA_W-1:0]             tableLatch,
  output logic      [ADDR_W-2:0]             memAddr,
  output logic                               memRdEn,
  output logic                               busy,
  output logic                               statusHold,
  output logic      [1:0]                    quarter
);
  // the logic splits a word into exactly two bytes by pointer bit zero
  if (ADDR_W < 2 || WORD_W != 2 * DATA_W) begin : g_bad_params
    $error("pmtr_table_read: needs ADDR_W >= 2 and WORD_W == 2*DATA_W");
  end

  // state
  logic [1:0]                       qPhase_reg;   // quarter counter
  pmtr_pkg::pmtr_state_e            state_reg;    // sequencer state
  pmtr_pkg::pmtr_state_e            state_next;
  logic [pmtr_pkg::MODE_W-1:0]      mode_reg;     // captured update mode
  logic [ADDR_W-1:0]                ptr_reg;      // byte pointer
  logic [ADDR_W-1:0]                ptr_next;
  logic [DATA_W-1:0]                latch_reg;    // table latch
  logic [ADDR_W-2:0]                memAddr_reg;  // word address to memory
  logic                             memRdEn_reg;  // read strobe in Q2
  logic [ADDR_W-1:0]                ptrStepped;   // pointer plus or minus one
  logic                             stepDown;     // decrement select
  logic                             accept;       // opcode taken this edge
  logic                             opcMatch;     // opcode is a table read
  logic                             preStep;      // pre-increment edge
  logic                             postStep;     // post update edge
  logic                             latchWrite;   // latch write edge
  logic [DATA_W-1:0]                selByte;      // byte picked from word

  // opcode decode: only the fixed pattern counts, mode rides in the low bits
  assign opcMatch = (instrWord[pmtr_pkg::OPC_W-1:pmtr_pkg::MODE_W] == pmtr_pkg::OPC_FIXED);

  // the decoder offers an instruction at Q1; only taken when idle
  assign accept = instrValid && opcMatch && (qPhase_reg == pmtr_pkg::Q1)
                  && (state_reg == pmtr_pkg::PMTR_IDLE);

  // pre-increment lands at the end of the decode cycle so the read sees it
  assign preStep    = (state_reg == pmtr_pkg::PMTR_DECODE) && (qPhase_reg == pmtr_pkg::Q4)
                      && (mode_reg == pmtr_pkg::MODE_PRE_INC);
  // post modes adjust on the same edge as the latch write, after the read
  assign latchWrite = (state_reg == pmtr_pkg::PMTR_READ) && (qPhase_reg == pmtr_pkg::Q4);
  assign postStep   = latchWrite && ((mode_reg == pmtr_pkg::MODE_POST_INC)
                      || (mode_reg == pmtr_pkg::MODE_POST_DEC));

  // only the post-decrement mode steps downwards
  assign stepDown = (mode_reg == pmtr_pkg::MODE_POST_DEC);

  pmtr_ptr_step #(
    .WIDTH (ADDR_W)
  ) u_step (
    .ptrIn    (ptr_reg),
    .stepDown (stepDown),
    .ptrOut   (ptrStepped)
  );

  // byte select within the fetched word
  always_comb begin
    if (ptr_reg[0]) begin
      selByte = memRdData[WORD_W-1:DATA_W];
    end else begin
      selByte = memRdData[DATA_W-1:0];
    end
  end

  // quarter counter, free running from reset
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      qPhase_reg <= pmtr_pkg::Q1;
    end else begin
      qPhase_reg <= qPhase_reg + 2'h1;
    end
  end

  // next state: one decode cycle then one read cycle
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      pmtr_pkg::PMTR_IDLE: begin
        if (accept) begin
          state_next = pmtr_pkg::PMTR_DECODE;
        end
      end
      pmtr_pkg::PMTR_DECODE: begin
        if (qPhase_reg == pmtr_pkg::Q4) begin
          state_next = pmtr_pkg::PMTR_READ;
        end
      end
      pmtr_pkg::PMTR_READ: begin
        if (qPhase_reg == pmtr_pkg::Q4) begin
          state_next = pmtr_pkg::PMTR_IDLE;
        end
      end
      default: begin
        state_next = pmtr_pkg::PMTR_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_reg <= pmtr_pkg::PMTR_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // mode capture at accept; held for the whole instruction
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mode_reg <= pmtr_pkg::MODE_KEEP;
    end else if (accept) begin
      mode_reg <= instrWord[pmtr_pkg::MODE_W-1:0];
    end
  end

  // pointer next value; a core load while busy is ignored so that the
  // address under read cannot shift mid-instruction
  always_comb begin
    ptr_next = ptr_reg;
    if (preStep || postStep) begin
      ptr_next = ptrStepped;
    end else if (ptrLoad && (state_reg == pmtr_pkg::PMTR_IDLE)) begin
      ptr_next = ptrLoadData;
    end
  end

  // full byte address register, every byte of the space reachable
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ptr_reg <= pmtr_pkg::PTR_RST;
    end else begin
      ptr_reg <= ptr_next;
    end
  end

  // memory address and strobe: address set at Q1, strobe spans Q2
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      memAddr_reg <= '0;
      memRdEn_reg <= 1'b0;
    end else begin
      if ((state_next == pmtr_pkg::PMTR_READ) && (state_reg == pmtr_pkg::PMTR_DECODE)) begin
        memAddr_reg <= ptr_next[ADDR_W-1:1];
      end
      memRdEn_reg <= (state_reg == pmtr_pkg::PMTR_READ) && (qPhase_reg == pmtr_pkg::Q1);
    end
  end

  // latch write at the end of Q4; memory holds its word since the address stands
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      latch_reg <= pmtr_pkg::LATCH_RST;
    end else if (latchWrite) begin
      latch_reg <= selByte;
    end
  end

  // outputs
  assign tablePointer = ptr_reg;
  assign tableLatch   = latch_reg;
  assign memAddr      = memAddr_reg;
  assign memRdEn      = memRdEn_reg;
  assign quarter      = qPhase_reg;
  assign busy         = (state_reg != pmtr_pkg::PMTR_IDLE);
  // tells the arithmetic unit to keep every status flag as it is
  assign statusHold   = busy;

  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  a_low_byte: assert property (latchWrite && !ptr_reg[0] |=> tableLatch == $past(memRdData[DATA_W-1:0]))
    else $error("low byte not latched");
  a_high_byte: assert property (latchWrite && ptr_reg[0] |=> tableLatch == $past(memRdData[WORD_W-1:DATA_W]))
    else $error("high byte not latched");
  // a core load may still land on the accept edge itself, so the hold is watched from one cycle later
  a_keep_ptr: assert property (accept && instrWord[1:0] == pmtr_pkg::MODE_KEEP
                               |=> ##1 $stable(tablePointer)[*7])
    else $error("pointer moved in keep mode");
  a_post_inc: assert property (latchWrite && mode_reg == pmtr_pkg::MODE_POST_INC
                               |=> tablePointer == ADDR_W'($past(tablePointer) + 1))
    else $error("post increment wrong");
  a_post_dec: assert property (latchWrite && mode_reg == pmtr_pkg::MODE_POST_DEC
                               |=> tablePointer == ADDR_W'($past(tablePointer) - 1))
    else $error("post decrement wrong");
  // the stepped pointer must already drive the word address when the strobe rises
  a_pre_inc: assert property (accept && instrWord[pmtr_pkg::MODE_W-1:0] == pmtr_pkg::MODE_PRE_INC
                              |-> ##4 (tablePointer == ADDR_W'($past(tablePointer, 3) + 1)
                                       && memAddr == tablePointer[ADDR_W-1:1]) ##1 memRdEn)
    else $error("pre increment not before read");
  a_read_addr: assert property (memRdEn |-> memAddr == tablePointer[ADDR_W-1:1])
    else $error("read address differs from pointer");
  a_read_q2: assert property (memRdEn |-> state_reg == pmtr_pkg::PMTR_READ && qPhase_reg == pmtr_pkg::Q2)
    else $error("read strobe outside Q2");
  a_two_cycles: assert property (accept |=> statusHold[*7] ##1 !busy)
    else $error("table read not two cycles");
  // decode judged from the raw instruction bits, not from the decoder's own match
  a_bad_opcode: assert property (instrValid && !busy
                                 && instrWord[pmtr_pkg::OPC_W-1:pmtr_pkg::MODE_W] != pmtr_pkg::OPC_FIXED |=> !busy)
    else $error("foreign opcode started a read");
  // a matching offer at Q1 while idle must start the sequence on the next cycle
  a_take_opcode: assert property (instrValid && !busy && quarter == pmtr_pkg::Q1
                                  && instrWord[pmtr_pkg::OPC_W-1:pmtr_pkg::MODE_W] == pmtr_pkg::OPC_FIXED |=> busy)
    else $error("table read opcode not taken");

  c_keep: cover property (accept && instrWord[1:0] == pmtr_pkg::MODE_KEEP);
  c_post_inc: cover property (accept && instrWord[1:0] == pmtr_pkg::MODE_POST_INC);
  c_post_dec: cover property (accept && instrWord[1:0] == pmtr_pkg::MODE_POST_DEC);
  c_pre_inc: cover property (accept && instrWord[1:0] == pmtr_pkg::MODE_PRE_INC);
endmodule : pmtr_table_read

// *** core/pmtr_pkg.sv ***
package pmtr_pkg;
  localparam int ADDR_W = 21;             // byte pointer width
  localparam int DATA_W = 8;              // latch width
  localparam int WORD_W = 16;             // program memory word width
  localparam int MODE_W = 2;              // pointer update field width
  localparam int OPC_W  = 16;             // instruction width

  // fixed upper opcode bits, compared against instruction bits 15..2
  localparam logic [OPC_W-MODE_W-1:0] OPC_FIXED = 14'h0002;

  // pointer update modes carried in the low opcode bits
  localparam logic [MODE_W-1:0] MODE_KEEP     = 2'h0;
  localparam logic [MODE_W-1:0] MODE_POST_INC = 2'h1;
  localparam logic [MODE_W-1:0] MODE_POST_DEC = 2'h2;
  localparam logic [MODE_W-1:0] MODE_PRE_INC  = 2'h3;

  // quarter phases of one instruction cycle
  localparam logic [1:0] Q1 = 2'h0;
  localparam logic [1:0] Q2 = 2'h1;
  localparam logic [1:0] Q3 = 2'h2;
  localparam logic [1:0] Q4 = 2'h3;

  // reset values
  localparam logic [ADDR_W-1:0] PTR_RST   = 21'h0_0000;
  localparam logic [DATA_W-1:0] LATCH_RST = 8'h00;

  // sequencer states
  typedef enum logic [1:0] {
    PMTR_IDLE,
    PMTR_DECODE,
    PMTR_READ
  } pmtr_state_e;
endpackage : pmtr_pkg

// *** core/pmtr_ptr_step.sv ***
`timescale 1ns/1ps
// one-step pointer adjuster, shared by the pre and post update paths
module pmtr_ptr_step #(
  parameter int WIDTH = 21
) (
  input  wire logic [WIDTH-1:0] ptrIn,
  input  wire logic             stepDown,
  output logic      [WIDTH-1:0] ptrOut
);
  // wraps at both ends of the address space, as a plain counter would
  always_comb begin
    if (stepDown) begin
      ptrOut = ptrIn - WIDTH'(1);
    end else begin
      ptrOut = ptrIn + WIDTH'(1);
    end
  end
endmodule : pmtr_ptr_step

// *** tb/pmtr_prog_mem.sv ***
`timescale 1ns/1ps
// program memory stand-in: the word follows the address, answered a cycle late
module pmtr_prog_mem (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic [19:0] memAddr,
  input  wire logic        memRdEn,
  output logic      [15:0] memRdData
);
  logic [15:0] word_reg;  // word fetched by the last strobe
  logic [1:0]  hold_reg;  // cycles the word stays valid
  // slow answer on purpose: data is only there after the strobe edge
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      word_reg <= 16'h0000;
      hold_reg <= 2'h0;
    end else if (memRdEn) begin
      word_reg <= {memAddr[7:0] ^ 8'h3C, memAddr[7:0] ^ 8'hC3};
      hold_reg <= 2'h3;
    end else if (hold_reg != 2'h0) begin
      hold_reg <= hold_reg - 2'h1;
    end
  end
  // outside the hold window show the inverse, so stale data never matches
  assign memRdData = (hold_reg != 2'h0) ? word_reg : ~word_reg;
endmodule : pmtr_prog_mem

// *** tb/pmtr_table_read_tb.sv ***
`timescale 1ns/1ps
`define CHK(g, e) begin totalChecks++; if ((g) !== (e)) begin nErrors++; $display("FAIL t=%0t got %h exp %h", $time, g, e); end end
module pmtr_table_read_tb;
  logic        core_clk    = 1'b0;
  logic        rst         = 1'b1;
  logic [15:0] instrWord   = 16'h0000;
  logic        instrValid  = 1'b0;
  logic        ptrLoad     = 1'b0;
  logic [20:0] ptrLoadData = 21'h00_0000;
  logic [15:0] memRdData;
  logic [20:0] tablePointer;
  logic [7:0]  tableLatch;
  logic [19:0] memAddr;
  logic        memRdEn;
  logic        busy;
  logic        statusHold;
  logic [1:0]  quarter;
  int          nErrors     = 0;
  int          totalChecks = 0;
  int          cycles      = 0;

  pmtr_table_read DUT (.core_clk(core_clk), .rst(rst), .instrWord(instrWord), .instrValid(instrValid),
    .ptrLoad(ptrLoad), .ptrLoadData(ptrLoadData), .memRdData(memRdData), .tablePointer(tablePointer),
    .tableLatch(tableLatch), .memAddr(memAddr), .memRdEn(memRdEn), .busy(busy),
    .statusHold(statusHold), .quarter(quarter));
  pmtr_prog_mem mem (.core_clk(core_clk), .rst(rst), .memAddr(memAddr), .memRdEn(memRdEn),
    .memRdData(memRdData));

  // 10 MHz clock
  always #50 core_clk = ~core_clk;

  // hang guard, far above the roughly 135 cycles the tests need
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 2000) begin
      nErrors++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("checks %0d errors %0d", totalChecks, nErrors);
    if (nErrors == 0 && totalChecks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : stop_test

  // inputs always move 10 ns after the rising edge
  task automatic step();
    @(posedge core_clk);
    #10;
  endtask : step

  task automatic load_ptr(input logic [20:0] p);
    ptrLoad = 1'b1;
    ptrLoadData = p;
    step();
    ptrLoad = 1'b0;
    `CHK(tablePointer, p)
  endtask : load_ptr

  // one full read; spoil tries a pointer write in mid-operation
  task automatic run_read(input logic [1:0] mode, input logic [20:0] p, input logic [20:0] expP,
                          input bit spoil);
    int          nBusy;
    int          nStrobe;
    logic [20:0] rdP;
    nBusy = 0;
    nStrobe = 0;
    rdP = (mode == pmtr_pkg::MODE_PRE_INC) ? p + 21'h00_0001 : p;
    load_ptr(p);
    for (int i = 0; i < 8 && quarter !== 2'h0; i++) step();
    instrWord = {pmtr_pkg::OPC_FIXED, mode};
    instrValid = 1'b1;
    step();
    instrValid = 1'b0;
    ptrLoadData = ~p;
    for (int i = 0; i < 12 && busy !== 1'b0; i++) begin
      nBusy++;
      ptrLoad = spoil && (i == 2);
      `CHK(statusHold, 1'b1)
      if (memRdEn === 1'b1) begin
        nStrobe++;
        `CHK(memAddr, rdP[20:1])
      end
      step();
    end
    ptrLoad = 1'b0;
    `CHK(nBusy, 7)
    `CHK(nStrobe, 1)
    `CHK(quarter, 2'h0)
    step();
    `CHK(tableLatch, rdP[0] ? rdP[8:1] ^ 8'h3C : rdP[8:1] ^ 8'hC3)
    `CHK(tablePointer, expP)
  endtask : run_read

  // every mode, including wrap at both ends of the pointer range
  task automatic test_modes();
    logic [1:0]  md [5] = '{2'h1, 2'h3, 2'h2, 2'h0, 2'h3};
    logic [20:0] pt [5] = '{21'h00_A356, 21'h01_A357, 21'h00_0000, 21'h1F_FFFF, 21'h1F_FFFF};
    logic [20:0] ex [5] = '{21'h00_A357, 21'h01_A358, 21'h1F_FFFF, 21'h1F_FFFF, 21'h00_0000};
    for (int i = 0; i < 5; i++) run_read(md[i], pt[i], ex[i], 1'b0);
    $display("test_modes done");
  endtask : test_modes

  // near-miss opcodes (one is the write form) must start nothing;
  // the last case is a good opcode offered one quarter late
  task automatic test_refused();
    logic [13:0] bad [3] = '{14'h0003, 14'h0000, pmtr_pkg::OPC_FIXED};
    for (int k = 0; k < 3; k++) begin
      load_ptr(21'h00_1234);
      for (int i = 0; i < 8 && quarter !== 2'h0; i++) step();
      if (k == 2) step();
      instrWord = {bad[k], 2'h1};
      instrValid = 1'b1;
      step();
      instrValid = 1'b0;
      `CHK(busy, 1'b0)
      repeat (8) step();
      `CHK(busy, 1'b0)
      `CHK(tablePointer, 21'h00_1234)
    end
    $display("test_refused done");
  endtask : test_refused

  // a second opcode offered in the first idle Q1 after the first one ends is taken at once
  task automatic test_back_to_back();
    load_ptr(21'h00_0100);
    for (int i = 0; i < 8 && quarter !== 2'h0; i++) step();
    instrWord = {pmtr_pkg::OPC_FIXED, pmtr_pkg::MODE_POST_INC};
    instrValid = 1'b1;
    step();
    instrValid = 1'b0;
    for (int i = 0; i < 12 && busy !== 1'b0; i++) step();
    instrValid = 1'b1;
    step();
    instrValid = 1'b0;
    `CHK(busy, 1'b1)
    `CHK(tableLatch, 8'h43)
    for (int i = 0; i < 12 && busy !== 1'b0; i++) step();
    step();
    `CHK(tableLatch, 8'hBC)
    `CHK(tablePointer, 21'h00_0102)
    $display("test_back_to_back done");
  endtask : test_back_to_back

  // a pointer write during the read loses to the read in progress
  task automatic test_load_busy();
    run_read(2'h0, 21'h05_5AA1, 21'h05_5AA1, 1'b1);
    $display("test_load_busy done");
  endtask : test_load_busy

  initial begin
    repeat (6) @(posedge core_clk);
    #10;
    rst = 1'b0;
    `CHK(tablePointer, 21'h00_0000)
    `CHK(tableLatch, 8'h00)
    `CHK(busy, 1'b0)
    `CHK(memRdEn, 1'b0)
    `CHK(quarter, 2'h0)
    test_modes();
    test_refused();
    test_load_busy();
    test_back_to_back();
    stop_test();
  end
endmodule : pmtr_table_read_tb
